//--- dcff_pkg.sv
/*
  Package for the flag-timing buffer: register map, field positions, reset values,
  timing constants and the flag carrier type.
  Assumes a single 100 MHz clock and a plain strobe register port.
*/
`default_nettype none
package dcff_pkg;
  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int DCFF_WIDTH = 18;
  localparam int DCFF_DEPTH = 8;
  localparam int DCFF_CNT_W = 4;
  localparam int DCFF_OFF_W = 4;
  localparam int DCFF_ADDR_W = 4;
  localparam int DCFF_BUS_W = 32;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [DCFF_ADDR_W-1:0] DCFF_CTRL_ADDR = 4'h0;
  localparam logic [DCFF_ADDR_W-1:0] DCFF_EOFF_ADDR = 4'h4;
  localparam logic [DCFF_ADDR_W-1:0] DCFF_FOFF_ADDR = 4'h8;
  localparam logic [DCFF_ADDR_W-1:0] DCFF_STAT_ADDR = 4'hc;

  localparam int DCFF_CTRL_ASYNC_BIT = 0;
  localparam int DCFF_CTRL_HIZ_BIT = 1;

  localparam int DCFF_STAT_EMPTY_BIT = 0;
  localparam int DCFF_STAT_AE_BIT = 1;
  localparam int DCFF_STAT_HALF_BIT = 2;
  localparam int DCFF_STAT_AF_BIT = 3;
  localparam int DCFF_STAT_FULL_BIT = 4;
  localparam int DCFF_STAT_VALID_BIT = 5;
  localparam int DCFF_STAT_CNT_LSB = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DCFF_OFF_W-1:0] DCFF_EOFF_RESET = 4'h1;
  localparam logic [DCFF_OFF_W-1:0] DCFF_FOFF_RESET = 4'h1;
  localparam logic [DCFF_WIDTH-1:0] DCFF_Q_RESET = 18'h00000;
  localparam logic [DCFF_CNT_W-1:0] DCFF_CNT_ZERO = 4'h0;
  localparam logic [DCFF_CNT_W-1:0] DCFF_CNT_ONE = 4'h1;
  localparam logic [DCFF_CNT_W-1:0] DCFF_CNT_FULL = 4'h8;
  localparam logic [DCFF_CNT_W-1:0] DCFF_CNT_HALF = 4'h4;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int DCFF_CLK_PERIOD_NS = 10;
  localparam int DCFF_FLAG_DELAY_NS = 8;
  localparam int DCFF_FLAG_EXTRA_NS = 5;
  localparam int DCFF_SETTLE_CYC_I =
    (DCFF_FLAG_DELAY_NS + DCFF_FLAG_EXTRA_NS + DCFF_CLK_PERIOD_NS - 1) / DCFF_CLK_PERIOD_NS;
  localparam logic [3:0] DCFF_SETTLE_CYC = 4'(DCFF_SETTLE_CYC_I);
  localparam logic [3:0] DCFF_SETTLE_ZERO = 4'h0;
  localparam logic [3:0] DCFF_SETTLE_ONE = 4'h1;

  // ==========================================================================
  // Flag carrier
  // ==========================================================================
  typedef struct packed {
    logic full_flag;
    logic almost_full_flag;
    logic half_level_flag;
    logic almost_empty_flag;
    logic empty_flag;
  } dcff_flags_type;

  localparam dcff_flags_type DCFF_FLAGS_RESET = 5'h03;
endpackage : dcff_pkg
`default_nettype wire

//--- dcff_fifo.sv
/*
  Eight-word storage with valid and ready on both sides and a registered read port.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module dcff_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg != FULL_CNT);
  assign out_valid_o = (cnt_reg != '0);
  assign count_o = cnt_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST_PTR) ? '0 : PW'(p + 1'b1);
  endfunction : step

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o <= '0;
    end else if (pop) begin
      out_data_o <= mem_reg[rd_ptr_reg];
    end
  end

  // ==========================================================================
  // Pointers and count
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= step(rd_ptr_reg);
      end
      cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pop));
    end
  end
endmodule : dcff_fifo
`default_nettype wire

//--- dcff_top.sv
/*
  Flag-timing buffer: 18-bit stream buffer with full, empty, half-level and
  programmable almost flags, output drive control and a strobe register port.
  Assumes writer, reader and software all run on clk_i and drive inputs
  synchronously to it.
*/
// Chosen here: strobed register access and the register addresses.
// How it works
// R1: Full releases on edge after freeing read.
// R2: Empty releases on edge after landing write.
// R3: Synchronous almost-empty moves on following clock edge.
// R4: Reset works with clock running throughout.
// R5: After reset data low, or undriven if disabled.
// R6: First word follows empty release by one read.
// R7: First-word latency counted only at empty boundary.
// R8: Read at almost-empty edge leaves offset words.
// R9: Write at almost-full edge leaves full-minus-offset words.
// R10: Asynchronous almost flags invalid until settle time.
// R11: Writes ignored while full.
// R12: Reads ignored while empty.
// R13: Sync mode: flags update on their own edges.
// R14: Almost flag when count within offset of boundary.
// R15: Count visibility staged so release never early.
`timescale 1ns/1ns
`default_nettype none
module dcff_top
  import dcff_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [DCFF_WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic rd_en_i,
  output logic [DCFF_WIDTH-1:0] q_o,
  output logic q_oe_o,
  output logic q_valid_o,
  output logic full_flag_o,
  output logic empty_flag_o,
  output logic almost_full_flag_o,
  output logic almost_empty_flag_o,
  output logic half_level_flag_o,
  input wire logic [DCFF_ADDR_W-1:0] reg_addr_i,
  input wire logic [DCFF_BUS_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DCFF_BUS_W-1:0] reg_rdata_o
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic async_mode_reg;
  logic hiz_reg;
  logic [DCFF_OFF_W-1:0] eoff_reg;
  logic [DCFF_OFF_W-1:0] foff_reg;
  logic [3:0] settle_reg;
  logic [3:0] settle_next;
  dcff_flags_type flags_reg;
  dcff_flags_type flags_next;
  logic [DCFF_CNT_W-1:0] fifo_cnt;
  logic [DCFF_CNT_W-1:0] cnt_next;
  logic [DCFF_WIDTH-1:0] fifo_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic push;
  logic pop;
  logic q_valid_reg;
  logic [DCFF_BUS_W-1:0] rdata_reg;
  logic off_write;

  // ==========================================================================
  // Flag evaluation
  // ==========================================================================
  function automatic dcff_flags_type eval_flags(input logic [DCFF_CNT_W-1:0] cnt,
                                                input logic [DCFF_OFF_W-1:0] eoff,
                                                input logic [DCFF_OFF_W-1:0] foff);
    dcff_flags_type f;
    f.empty_flag = (cnt == DCFF_CNT_ZERO);
    f.full_flag = (cnt == DCFF_CNT_FULL);
    f.half_level_flag = (cnt > DCFF_CNT_HALF);
    f.almost_empty_flag = (cnt <= DCFF_CNT_W'(eoff)); // [R14] [R8]
    f.almost_full_flag = (cnt >= DCFF_CNT_W'(DCFF_CNT_FULL - DCFF_CNT_W'(foff))); // [R14] [R9]
    eval_flags = f;
  endfunction : eval_flags

  // ==========================================================================
  // Storage
  // ==========================================================================
  assign push = wr_en_i && !flags_reg.full_flag && fifo_in_ready; // [R11]
  assign pop = rd_en_i && !flags_reg.empty_flag && fifo_out_valid; // [R12]

  dcff_fifo #(
    .WIDTH(DCFF_WIDTH),
    .DEPTH(DCFF_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_data_i(wr_data_i),
    .in_ready_o(fifo_in_ready),
    .out_ready_i(pop),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_data),
    .count_o(fifo_cnt)
  );

  // ==========================================================================
  // Flags
  // ==========================================================================
  always_comb begin
    cnt_next = DCFF_CNT_W'(fifo_cnt + DCFF_CNT_W'(push) - DCFF_CNT_W'(pop));
    flags_next = eval_flags(cnt_next, eoff_reg, foff_reg);
  end

  // Flags settle on the edge right after the causing access, never earlier.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_reg <= DCFF_FLAGS_RESET; // [R4]
    end else begin
      flags_reg.full_flag <= flags_next.full_flag; // [R1] [R15]
      flags_reg.empty_flag <= flags_next.empty_flag; // [R2] [R15] [R7]
      flags_reg.half_level_flag <= flags_next.half_level_flag;
      flags_reg.almost_empty_flag <= flags_next.almost_empty_flag; // [R3] [R13]
      flags_reg.almost_full_flag <= flags_next.almost_full_flag; // [R13]
    end
  end

  // Counts down after an offset write while asynchronous almost flags are unsettled.
  always_comb begin
    settle_next = settle_reg;
    if (off_write && async_mode_reg) begin
      settle_next = DCFF_SETTLE_CYC; // [R10]
    end else if (settle_reg != DCFF_SETTLE_ZERO) begin
      settle_next = 4'(settle_reg - DCFF_SETTLE_ONE);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_reg <= DCFF_SETTLE_ZERO;
    end else begin
      settle_reg <= settle_next; // [R10]
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // The word leaves the buffer's output register on the read edge itself.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_valid_reg <= 1'b0;
    end else begin
      q_valid_reg <= pop; // [R6] [R7]
    end
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  assign off_write = reg_wr_i &&
    ((reg_addr_i == DCFF_EOFF_ADDR) || (reg_addr_i == DCFF_FOFF_ADDR));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      async_mode_reg <= 1'b0;
      hiz_reg <= 1'b0;
      eoff_reg <= DCFF_EOFF_RESET;
      foff_reg <= DCFF_FOFF_RESET;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        DCFF_CTRL_ADDR: begin
          async_mode_reg <= reg_wdata_i[DCFF_CTRL_ASYNC_BIT];
          hiz_reg <= reg_wdata_i[DCFF_CTRL_HIZ_BIT]; // [R5]
        end
        DCFF_EOFF_ADDR: begin
          eoff_reg <= reg_wdata_i[DCFF_OFF_W-1:0];
        end
        DCFF_FOFF_ADDR: begin
          foff_reg <= reg_wdata_i[DCFF_OFF_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      rdata_reg <= '0;
      unique case (reg_addr_i)
        DCFF_CTRL_ADDR: begin
          rdata_reg[DCFF_CTRL_ASYNC_BIT] <= async_mode_reg;
          rdata_reg[DCFF_CTRL_HIZ_BIT] <= hiz_reg;
        end
        DCFF_EOFF_ADDR: begin
          rdata_reg[DCFF_OFF_W-1:0] <= eoff_reg;
        end
        DCFF_FOFF_ADDR: begin
          rdata_reg[DCFF_OFF_W-1:0] <= foff_reg;
        end
        DCFF_STAT_ADDR: begin
          rdata_reg[DCFF_STAT_EMPTY_BIT] <= flags_reg.empty_flag;
          rdata_reg[DCFF_STAT_AE_BIT] <= flags_reg.almost_empty_flag;
          rdata_reg[DCFF_STAT_HALF_BIT] <= flags_reg.half_level_flag;
          rdata_reg[DCFF_STAT_AF_BIT] <= flags_reg.almost_full_flag;
          rdata_reg[DCFF_STAT_FULL_BIT] <= flags_reg.full_flag;
          rdata_reg[DCFF_STAT_VALID_BIT] <= (settle_reg == DCFF_SETTLE_ZERO); // [R10]
          rdata_reg[DCFF_STAT_CNT_LSB +: DCFF_CNT_W] <= fifo_cnt;
        end
        default: begin
        end
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The buffer's output register resets low and holds the last word while empty.
  assign q_o = fifo_data; // [R5] [R6]
  assign q_valid_o = q_valid_reg;
  assign full_flag_o = flags_reg.full_flag;
  assign empty_flag_o = flags_reg.empty_flag;
  assign almost_full_flag_o = flags_reg.almost_full_flag;
  assign almost_empty_flag_o = flags_reg.almost_empty_flag;
  assign half_level_flag_o = flags_reg.half_level_flag;
  assign reg_rdata_o = rdata_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_oe_o <= 1'b1;
      wr_ready_o <= 1'b1;
    end else begin
      q_oe_o <= !hiz_reg; // [R5]
      wr_ready_o <= !flags_next.full_flag; // [R11]
    end
  end
endmodule : dcff_top
`default_nettype wire

//--- dcff_top_assertions.sv
/*
  Checker for the flag-timing buffer, bound to dcff_top.
  Assumes one clock; the almost flags move on the same edges in both flag modes.
*/
`timescale 1ns/1ns
`default_nettype none
module dcff_top_checker
  import dcff_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [DCFF_WIDTH-1:0] q_o,
  input wire logic q_valid_o,
  input wire logic wr_ready_o,
  input wire logic full_flag_o,
  input wire logic empty_flag_o,
  input wire logic almost_full_flag_o,
  input wire logic almost_empty_flag_o,
  input wire logic half_level_flag_o,
  input wire logic [DCFF_ADDR_W-1:0] reg_addr_i,
  input wire logic [DCFF_BUS_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i
);
  // ====
  // Reference count and offsets
  // ====
  logic [DCFF_CNT_W-1:0] cnt_reg;
  logic [DCFF_OFF_W-1:0] eoff_reg;
  logic [DCFF_OFF_W-1:0] foff_reg;
  logic wr_take;
  logic rd_take;
  assign wr_take = wr_en_i & ~full_flag_o;
  assign rd_take = rd_en_i & ~empty_flag_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= DCFF_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_reg + DCFF_CNT_W'(wr_take) - DCFF_CNT_W'(rd_take);
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eoff_reg <= DCFF_EOFF_RESET;
      foff_reg <= DCFF_FOFF_RESET;
    end else if (reg_wr_i && reg_addr_i == DCFF_EOFF_ADDR) begin
      eoff_reg <= reg_wdata_i[DCFF_OFF_W-1:0];
    end else if (reg_wr_i && reg_addr_i == DCFF_FOFF_ADDR) begin
      foff_reg <= reg_wdata_i[DCFF_OFF_W-1:0];
    end
  end
  // ====
  // Properties
  // ====
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_taken;
    rd_take;
  endsequence
  sequence s_word_out;
    ##1 q_valid_o;
  endsequence
  a_full_count: assert property (full_flag_o == (cnt_reg == DCFF_CNT_FULL))
    else $error("full flag disagrees with word count");
  a_empty_count: assert property (empty_flag_o == (cnt_reg == DCFF_CNT_ZERO))
    else $error("empty flag disagrees with word count");
  a_afull_level: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2) |->
    almost_full_flag_o == (cnt_reg >= DCFF_CNT_FULL - foff_reg))
    else $error("almost full flag wrong for count");
  a_aempty_level: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2) |->
    almost_empty_flag_o == (cnt_reg <= eoff_reg))
    else $error("almost empty flag wrong for count");
  a_half_level: assert property (half_level_flag_o == (cnt_reg > DCFF_CNT_HALF))
    else $error("half level flag wrong for count");
  a_first_word: assert property (s_rd_taken |-> s_word_out)
    else $error("read word not presented one cycle after read");
  a_no_empty_read: assert property (q_valid_o |-> $past(rd_take))
    else $error("word presented without an accepted read");
  a_q_holds: assert property (!q_valid_o |-> $stable(q_o))
    else $error("read data changed without a new word");
  a_ready_full: assert property (wr_ready_o != full_flag_o)
    else $error("write ready does not mirror full flag");
endmodule : dcff_top_checker
bind dcff_top dcff_top_checker i_dcff_top_checker (.clk_i, .rst_n_i, .wr_en_i, .rd_en_i,
  .q_o, .q_valid_o, .wr_ready_o, .full_flag_o, .empty_flag_o, .almost_full_flag_o,
  .almost_empty_flag_o, .half_level_flag_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i);
`default_nettype wire

//--- dcff_stream_partner.sv
/*
  Writer and reader model on clk_i.
  Assumes the bench raises wr_go_i and rd_go_i right after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module dcff_stream_partner
  import dcff_pkg::*;
#(
  parameter logic [DCFF_WIDTH-1:0] DATA_BASE = 18'h2a5c0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_go_i,
  input wire logic rd_go_i,
  input wire logic full_flag_i,
  output logic wr_en_o,
  output logic [DCFF_WIDTH-1:0] wr_data_o,
  output logic rd_en_o
);
  // ====
  // Writer and reader
  // ====
  logic [DCFF_WIDTH-1:0] seq_reg;
  assign wr_data_o = wr_en_o ? seq_reg : ~seq_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b0;
    end else begin
      wr_en_o <= wr_go_i;
      rd_en_o <= rd_go_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_reg <= DATA_BASE;
    end else if (wr_en_o && !full_flag_i) begin
      seq_reg <= seq_reg + 18'h00001;
    end
  end
endmodule : dcff_stream_partner
`default_nettype wire

//--- dcff_top_tb.sv
/*
  Self-checking bench for dcff_top with a stream partner.
  Assumes dcff_pkg, the checker and the partner are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module dcff_top_tb;
  import dcff_pkg::*;
  localparam logic [DCFF_WIDTH-1:0] BASE = 18'h2a5c0;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic wr_en, rd_en, q_oe, q_valid, wr_ready, full, empty, afull, aempty, half;
  logic [DCFF_WIDTH-1:0] wr_data, q, exp_word;
  logic [DCFF_ADDR_W-1:0] reg_addr = 4'h0;
  logic [DCFF_BUS_W-1:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  dcff_top i_dcff_top (.clk_i, .rst_n_i, .wr_en_i(wr_en), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .rd_en_i(rd_en), .q_o(q), .q_oe_o(q_oe), .q_valid_o(q_valid),
    .full_flag_o(full), .empty_flag_o(empty), .almost_full_flag_o(afull),
    .almost_empty_flag_o(aempty), .half_level_flag_o(half), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  dcff_stream_partner #(.DATA_BASE(BASE)) i_dcff_stream_partner (.clk_i, .rst_n_i,
    .wr_go_i(wr_go), .rd_go_i(rd_go), .full_flag_i(full), .wr_en_o(wr_en),
    .wr_data_o(wr_data), .rd_en_o(rd_en));
  // ====
  // Shared tasks
  // ====
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      err_count = err_count + 1;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  task automatic push(input int n);
    @(posedge clk_i);
    wr_go <= 1'b1;
    repeat (n) @(posedge clk_i);
    wr_go <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : push
  task automatic pop(input int n);
    int got;
    got = 0;
    @(posedge clk_i);
    rd_go <= 1'b1;
    repeat (n + 8) begin
      @(posedge clk_i);
      #1;
      if (q_valid === 1'b1) begin
        chk(32'(q), 32'(exp_word), "word order");
        exp_word = exp_word + 18'h00001;
        got++;
      end
    end
    @(posedge clk_i);
    rd_go <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(32'(got), 32'(n), "word count, extra reads refused");
  endtask : pop
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    chk({q, q_oe, q_valid, empty, aempty, full}, {18'h0, 5'h16}, "outputs in reset");
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    exp_word = BASE;
    @(posedge clk_i);
    #1;
    chk({q, q_oe, wr_ready, empty, aempty, full}, {18'h0, 5'h1e}, "after reset");
  endtask : do_reset
  // ====
  // Scenarios
  // ====
  task automatic t_fill();
    push(11);
    chk({full, wr_ready, afull, half, empty}, 32'h16, "flags when full");
    reg_read(DCFF_STAT_ADDR, rv);
    chk(rv, 32'h83c, "status when full");
    pop(8);
    chk({empty, aempty, 18'h0} | 32'(q), {2'h3, BASE + 18'h7}, "empty keeps last word");
  endtask : t_fill
  task automatic t_latency();
    int n;
    n = 0;
    @(posedge clk_i);
    wr_go <= 1'b1;
    rd_go <= 1'b1;
    @(posedge clk_i);
    wr_go <= 1'b0;
    #1;
    while (empty !== 1'b0 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    n = 0;
    while (q_valid !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(32'(n), 32'd1, "first word latency");
    chk(32'(q), 32'(exp_word), "first word value");
    exp_word = exp_word + 18'h00001;
    @(posedge clk_i);
    rd_go <= 1'b0;
  endtask : t_latency
  task automatic t_regs();
    reg_write(DCFF_EOFF_ADDR, 32'h3);
    push(3);
    chk(32'(aempty), 32'h1, "almost empty at offset");
    push(1);
    chk(32'(aempty), 32'h0, "almost empty above offset");
    reg_write(DCFF_FOFF_ADDR, 32'h4);
    repeat (3) @(posedge clk_i);
    #1;
    chk(32'(afull), 32'h1, "almost full at offset");
    reg_read(4'h2, rv);
    chk(rv, 32'h0, "unmapped read");
    reg_read(DCFF_EOFF_ADDR, rv);
    chk(rv, 32'h3, "offset read back");
    reg_write(DCFF_CTRL_ADDR, 32'h1);
    reg_write(DCFF_EOFF_ADDR, 32'h2);
    reg_read(DCFF_STAT_ADDR, rv);
    chk(rv, 32'h408, "almost flags unsettled after offset write");
    reg_read(DCFF_STAT_ADDR, rv);
    chk(rv, 32'h428, "almost flags settled");
    reg_write(DCFF_CTRL_ADDR, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    chk(32'(q_oe), 32'h0, "output drive off");
    reg_write(DCFF_CTRL_ADDR, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    chk(32'(q_oe), 32'h1, "output drive on");
  endtask : t_regs
  task automatic t_midreset();
    @(posedge clk_i);
    do_reset();
    reg_read(DCFF_EOFF_ADDR, rv);
    chk(rv, 32'(DCFF_EOFF_RESET), "offset after reset");
    push(2);
    pop(2);
  endtask : t_midreset
  initial begin
    exp_word = BASE;
    do_reset();
    t_fill();
    t_latency();
    t_regs();
    t_midreset();
    summarize();
  end
endmodule : dcff_top_tb
`default_nettype wire
